// ---- inc/inve_pkg.sv ----
// Package: register map, field positions, vectors and source layout
package inve_pkg;
  // Register offsets (byte addresses of the plain register port)
  localparam logic [3:0] ADDR_NODE_EN_LOW  = 4'h0;
  localparam logic [3:0] ADDR_NODE_EN_HIGH = 4'h1;
  localparam logic [3:0] ADDR_NM_CTRL      = 4'h2;
  localparam logic [3:0] ADDR_SRC_FLAGS_LO = 4'h3;
  localparam logic [3:0] ADDR_SRC_FLAGS_HI = 4'h4;
  localparam logic [3:0] ADDR_NM_FLAGS     = 4'h5;
  localparam logic [3:0] ADDR_PENDING_LO   = 4'h6;
  localparam logic [3:0] ADDR_PENDING_HI   = 4'h7;
  // Reset values
  localparam logic [7:0] RST_NODE_EN_LOW   = 8'h00;
  localparam logic [7:0] RST_NODE_EN_HIGH  = 8'h00;
  localparam logic [7:0] RST_NM_CTRL       = 8'h00;
  // Field positions in the first enable register
  localparam int         POS_GLOBAL_MASK   = 7;
  localparam int         POS_RESERVED      = 6;
  localparam logic [7:0] LOW_WRITE_MASK    = 8'hbf;
  // Non-maskable enable register: bits 0..6 writable, bit 3 reserved here
  localparam logic [7:0] NM_WRITE_MASK     = 8'h77;
  // Node count and source layout
  localparam int         NUM_NODES         = 14;
  localparam int         NUM_SRC           = 16;
  localparam int         NUM_NM_SRC        = 7;
  // Status flag indices (shared nodes keep one flag per source)
  localparam int SRC_EXT0 = 0;
  localparam int SRC_TMR0 = 1;
  localparam int SRC_EXT1 = 2;
  localparam int SRC_TMR1 = 3;
  localparam int SRC_URX  = 4;
  localparam int SRC_UTX  = 5;
  localparam int SRC_TMR2 = 6;
  localparam int SRC_FDIV = 7;
  localparam int SRC_LIN  = 8;
  localparam int SRC_ADC  = 9;
  localparam int SRC_SSC  = 10;
  localparam int SRC_EXT2 = 11;
  localparam int SRC_EXT3 = 12;
  localparam int SRC_EXT4 = 13;
  localparam int SRC_EXT5 = 14;
  localparam int SRC_EXT6 = 15;
  // Vector addresses
  localparam logic [15:0] VEC_NM   = 16'h0073;
  localparam logic [15:0] VEC_BASE = 16'h0003;
  localparam logic [15:0] VEC_STEP = 16'h0008;
endpackage

// ---- hw/inve_node_enable.sv ----
// Interrupt node enable, pending latch, masking and vectoring logic
//
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
// What this block does
// - Independent-flag events set flag; pending latched only while node enabled.
// - Timer 2, LIN, ext 2-6, ADC, SSC, capture/compare use independent flags.
// - Core acknowledge clears pending; status flag stays until software clears.
// - Writing node enable to zero also clears the latched pending request of nodes 5-13.
// - Global mask low hides maskable pending; latches kept, events still caught.
// - Non-maskable request ignores global mask; own flags, enables, ack clear.
// - Non-maskable vector 0073h, seven sources, all but source 3 with own enable.
// - Nodes 0-5 map to vectors 0003h to 002Bh in listed order.
// - Nodes 6-13 map to 0033h to 006Bh in steps of eight.
// - Node 5 shares timer 2, divider, LIN; node 9 shares ext 3-6.
// - Reset clears all node enables and non-maskable source enables.
// - Each maskable node has one enable bit, 1 enables, 0 disables.
// - First register: nodes 0-5 bits 0-5, reserved bit 6, mask bit 7.
// - Second register: nodes 6-13 in bits 0-7.
// - Reserved bit 6 reads zero; software writes zero.
// - Global mask zero blocks maskable requests; one passes them.
// - Timer 0/1, ext 0/1 flags are the pending request, cleared on ack.
// - UART flags are not cleared by acknowledge, only by software.
module inve_node_enable (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Register port
  input  wire logic [3:0]  regAddr,
  input  wire logic [7:0]  regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [7:0]  regRdata,
  // Event pulses: maskable sources, capture/compare lines, non-maskable
  input  wire logic [15:0] srcEvent,
  input  wire logic [3:0]  capcmpEvent,
  input  wire logic [6:0]  nmEvent,
  // Core side
  input  wire logic [13:0] nodeAck,
  input  wire logic        nmAck,
  output logic      [13:0] nodeReq,
  output logic             nmReq,
  output logic      [15:0] nodeVector [14],
  output logic      [15:0] nmVector
);
  logic [7:0]  enLow_q;
  logic [7:0]  enHigh_q;
  logic [7:0]  nmCtrl_q;
  logic [15:0] srcFlag_q;
  logic [6:0]  nmFlag_q;
  logic [13:0] pend_q;
  logic        nmPend_q;
  logic [13:0] nodeEn;
  logic [13:0] nodeEvent;
  logic        wrLow;
  logic        wrHigh;
  logic [15:0] flagClr;
  logic [6:0]  nmFlagClr;
  logic [13:0] pendFromFlag;
  logic        globalMask;

  assign wrLow  = regWr && regAddr == inve_pkg::ADDR_NODE_EN_LOW;
  assign wrHigh = regWr && regAddr == inve_pkg::ADDR_NODE_EN_HIGH;
  assign globalMask = enLow_q[inve_pkg::POS_GLOBAL_MASK];
  assign nodeEn = {enHigh_q, enLow_q[5:0]};

  // Node events gathered from sources; shared nodes OR their sources
  always_comb begin
    nodeEvent     = '0;
    nodeEvent[5]  = srcEvent[inve_pkg::SRC_TMR2] |
                    srcEvent[inve_pkg::SRC_FDIV] |
                    srcEvent[inve_pkg::SRC_LIN];
    nodeEvent[6]  = srcEvent[inve_pkg::SRC_ADC];
    nodeEvent[7]  = srcEvent[inve_pkg::SRC_SSC];
    nodeEvent[8]  = srcEvent[inve_pkg::SRC_EXT2];
    nodeEvent[9]  = |srcEvent[inve_pkg::SRC_EXT6:inve_pkg::SRC_EXT3];
    nodeEvent[13:10] = capcmpEvent;
  end

  // Software write-one-to-clear masks for the flag registers
  always_comb begin
    flagClr   = '0;
    nmFlagClr = '0;
    if (regWr && regAddr == inve_pkg::ADDR_SRC_FLAGS_LO) begin
      flagClr[7:0] = regWdata;
    end
    if (regWr && regAddr == inve_pkg::ADDR_SRC_FLAGS_HI) begin
      flagClr[15:8] = regWdata;
    end
    if (regWr && regAddr == inve_pkg::ADDR_NM_FLAGS) begin
      nmFlagClr = regWdata[6:0];
    end
  end

  // Enable registers
  always_ff @(posedge clk) begin
    if (!resetn) begin
      enLow_q  <= inve_pkg::RST_NODE_EN_LOW;
      enHigh_q <= inve_pkg::RST_NODE_EN_HIGH;
      nmCtrl_q <= inve_pkg::RST_NM_CTRL;
    end else begin
      if (wrLow) begin
        enLow_q <= regWdata & inve_pkg::LOW_WRITE_MASK;
      end
      if (wrHigh) begin
        enHigh_q <= regWdata;
      end
      if (regWr && regAddr == inve_pkg::ADDR_NM_CTRL) begin
        nmCtrl_q <= regWdata & inve_pkg::NM_WRITE_MASK;
      end
    end
  end

  // Source status flags; a new event wins over a software clear
  always_ff @(posedge clk) begin
    if (!resetn) begin
      srcFlag_q <= '0;
    end else begin
      for (int i = 0; i < inve_pkg::NUM_SRC; i++) begin
        if (srcEvent[i]) begin
          srcFlag_q[i] <= 1'b1;
        end else if (flagClr[i]) begin
          srcFlag_q[i] <= 1'b0;
        end else if (i <= inve_pkg::SRC_TMR1 && nodeAck[i]) begin
          srcFlag_q[i] <= 1'b0;
        end
      end
    end
  end

  // Nodes 0-4 take their pending state straight from the flags
  always_comb begin
    pendFromFlag    = '0;
    pendFromFlag[0] = srcFlag_q[inve_pkg::SRC_EXT0];
    pendFromFlag[1] = srcFlag_q[inve_pkg::SRC_TMR0];
    pendFromFlag[2] = srcFlag_q[inve_pkg::SRC_EXT1];
    pendFromFlag[3] = srcFlag_q[inve_pkg::SRC_TMR1];
    pendFromFlag[4] = srcFlag_q[inve_pkg::SRC_URX] |
                      srcFlag_q[inve_pkg::SRC_UTX];
  end

  // Latched pending requests for independent-flag nodes 5-13
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pend_q <= '0;
    end else begin
      for (int n = 5; n < inve_pkg::NUM_NODES; n++) begin
        if (nodeEvent[n] && nodeEn[n]) begin
          pend_q[n] <= 1'b1;
        end else if (nodeAck[n]) begin
          pend_q[n] <= 1'b0;
        end else if (!nodeEn[n]) begin
          pend_q[n] <= 1'b0;
        end
      end
      if (wrLow && !regWdata[5]) begin
        pend_q[5] <= 1'b0;
      end
      for (int n = 6; n < inve_pkg::NUM_NODES; n++) begin
        if (wrHigh && !regWdata[n-6]) begin
          pend_q[n] <= 1'b0;
        end
      end
      pend_q[4:0] <= '0;
    end
  end

  // Non-maskable flags and pending latch
  always_ff @(posedge clk) begin
    if (!resetn) begin
      nmFlag_q <= '0;
      nmPend_q <= 1'b0;
    end else begin
      for (int i = 0; i < inve_pkg::NUM_NM_SRC; i++) begin
        if (nmEvent[i]) begin
          nmFlag_q[i] <= 1'b1;
        end else if (nmFlagClr[i]) begin
          nmFlag_q[i] <= 1'b0;
        end
      end
      if (|(nmEvent & nmCtrl_q[6:0])) begin
        nmPend_q <= 1'b1;
      end else if (nmAck) begin
        nmPend_q <= 1'b0;
      end
    end
  end

  // Requests toward the core
  always_comb begin
    nmReq   = nmPend_q;
    nodeReq = '0;
    if (globalMask) begin
      nodeReq = (pend_q | (pendFromFlag & nodeEn));
    end
  end

  // Vector addresses, one per node
  always_comb begin
    nmVector = inve_pkg::VEC_NM;
    for (int n = 0; n < inve_pkg::NUM_NODES; n++) begin
      nodeVector[n] = inve_pkg::VEC_BASE +
                      16'(n) * inve_pkg::VEC_STEP;
    end
  end

  // Register read data, one cycle after the strobe
  always_ff @(posedge clk) begin
    if (!resetn) begin
      regRdata <= 8'h00;
    end else if (regRd) begin
      case (regAddr)
        inve_pkg::ADDR_NODE_EN_LOW:  regRdata <= enLow_q;
        inve_pkg::ADDR_NODE_EN_HIGH: regRdata <= enHigh_q;
        inve_pkg::ADDR_NM_CTRL:      regRdata <= nmCtrl_q;
        inve_pkg::ADDR_SRC_FLAGS_LO: regRdata <= srcFlag_q[7:0];
        inve_pkg::ADDR_SRC_FLAGS_HI: regRdata <= srcFlag_q[15:8];
        inve_pkg::ADDR_NM_FLAGS:     regRdata <= {1'b0, nmFlag_q};
        inve_pkg::ADDR_PENDING_LO:   regRdata <= {2'b00, nmPend_q,
                                                  pend_q[13:9]};
        inve_pkg::ADDR_PENDING_HI:   regRdata <= {pend_q[8:5], 4'h0};
        default:                     regRdata <= 8'h00;
      endcase
    end else begin
      regRdata <= 8'h00;
    end
  end

endmodule // inve_node_enable

// ---- test/inve_node_enable_chk.sv ----
// Assertions on the node enable block
`timescale 1ns/1ps
module inve_node_enable_chk (
  // Clock, reset, register writes
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic [3:0]  regAddr,
  input wire logic [7:0]  regWdata,
  input wire logic        regWr,
  // Events and core side
  input wire logic [15:0] srcEvent,
  input wire logic [6:0]  nmEvent,
  input wire logic [13:0] nodeAck,
  input wire logic        nmAck,
  input wire logic [13:0] nodeReq,
  input wire logic        nmReq
);
  logic [7:0] enLow_q, enHigh_q;
  // Mirror of both enable registers
  always_ff @(posedge clk) begin
    if (!resetn) begin
      enLow_q  <= 8'h00;
      enHigh_q <= 8'h00;
    end else if (regWr && regAddr == 4'h0) begin
      enLow_q <= regWdata;
    end else if (regWr && regAddr == 4'h1) begin
      enHigh_q <= regWdata;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence adcEvt;
    srcEvent[9] && enHigh_q[0] && enLow_q[7] && !regWr;
  endsequence
  req_set_a: assert property (
    adcEvt |=> nodeReq[6]) else $error("adc request missing");
  ack_clr_a: assert property (
    nodeAck[6] && !srcEvent[9] |=> !nodeReq[6]) else $error("adc ack");
  dis_clr_a: assert property (
    regWr && regAddr == 4'h0 && !regWdata[5] && srcEvent[8:6] == 3'h0
    |=> !nodeReq[5]) else $error("disable kept request");
  mask_blk_a: assert property (
    !enLow_q[7] |-> nodeReq == 14'h0) else $error("mask leaked");
  node_en_a: assert property (
    (nodeReq & ~{enHigh_q, enLow_q[5:0]}) == 14'h0) else $error("node off");
  nm_clr_a: assert property (
    nmAck && nmEvent == 7'h0 |=> !nmReq) else $error("nm ack");
  tmr0_clr_a: assert property (
    nodeAck[1] && !srcEvent[1] |=> !nodeReq[1]) else $error("timer ack");
  uart_keep_a: assert property (
    nodeReq[4] && nodeAck[4] && !regWr |=> nodeReq[4]) else $error("uart");
endmodule // inve_node_enable_chk
bind inve_node_enable inve_node_enable_chk chk (.clk, .resetn, .regAddr,
  .regWdata, .regWr, .srcEvent, .nmEvent, .nodeAck, .nmAck, .nodeReq,
  .nmReq);

// ---- test/inve_core_model.sv ----
// Core model: acknowledges one request at a time
`timescale 1ns/1ps
module inve_core_model (
  // Clock, reset and pace
  input wire logic         clk,
  input wire logic         resetn,
  input wire logic         ackOn,
  input wire logic         slow,
  // Requests in, acknowledges out
  input wire logic  [13:0] nodeReq,
  input wire logic         nmReq,
  output logic      [13:0] nodeAck,
  output logic             nmAck
);
  logic wait_q;
  always_ff @(posedge clk) begin
    if (!resetn || !ackOn || nodeAck != '0 || nmAck) begin
      nodeAck <= '0;
      nmAck   <= 1'h0;
      wait_q  <= slow;
    end else if (wait_q) begin
      wait_q <= 1'h0;
    end else begin
      nmAck   <= nmReq;
      nodeAck <= nmReq ? '0 : nodeReq & (~nodeReq + 14'h1);
    end
  end
endmodule // inve_core_model

// ---- test/inve_node_enable_bench.sv ----
// Bench of the node enable block
`timescale 1ns/1ps
module inve_node_enable_bench;
  logic        clk = 0, resetn = 0, regWr = 0, regRd = 0, rdLast = 0;
  logic        nmAck, nmReq, ackOn = 0, slow = 0;
  logic [3:0]  regAddr = '0, capcmpEvent = '0;
  logic [7:0]  regWdata = '0, regRdata, r, expQ [$];
  logic [6:0]  nmEvent = '0;
  logic [13:0] nodeAck, nodeReq;
  logic [15:0] srcEvent = '0, nmVector, nodeVector [14];
  int          errors = 0, n_compared = 0;
  always #2 clk = ~clk;
  inve_node_enable dut (.clk, .resetn, .regAddr, .regWdata, .regWr,
    .regRd, .regRdata, .srcEvent, .capcmpEvent, .nmEvent, .nodeAck,
    .nmAck, .nodeReq, .nmReq, .nodeVector, .nmVector);
  inve_core_model core (.clk, .resetn, .ackOn, .slow, .nodeReq, .nmReq,
    .nodeAck, .nmAck);
  task automatic chk(string nm, logic [15:0] s, e);
    n_compared++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic bus(logic w, logic [3:0] a, logic [7:0] d);
    @(posedge clk);
    {regWr, regRd, regAddr, regWdata} <= {w, !w, a, d};
    if (!w) expQ.push_back(d);
    @(posedge clk);
    {regWr, regRd} <= 2'h0;
  endtask
  task automatic hit(logic [15:0] s, logic [3:0] c, logic [6:0] m,
                     logic [14:0] e, a);
    @(posedge clk);
    {srcEvent, capcmpEvent, nmEvent} <= {s, c, m};
    @(posedge clk);
    {srcEvent, capcmpEvent, nmEvent} <= '0;
    @(negedge clk);
    chk("request", 16'({nmReq, nodeReq}), 16'(e));
    @(posedge clk);
    {ackOn, slow} <= {1'h1, 1'($urandom)};
    if (e != '0) begin
      for (int k = 0; k < 9 && nodeAck == '0 && !nmAck; k++)
        @(negedge clk);
      if (nodeAck == '0 && !nmAck) begin
        $display("unexpected acknowledge: none within bound");
        errors++;
        conclude();
      end
    end else begin
      repeat (4) @(negedge clk);
    end
    @(negedge clk);
    chk("after ack", 16'({nmReq, nodeReq}), 16'(a));
    @(posedge clk);
    ackOn <= 1'h0;
  endtask
  always @(negedge clk) begin
    if (rdLast)
      chk("regRdata", 16'(regRdata), 16'(expQ.pop_front()));
    rdLast = regRd;
  end
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    void'($urandom(25));
    r = 8'($urandom);
    repeat (20) @(posedge clk);
    resetn <= 1'h1;
    bus(0, 4'h0, 8'h00);
    bus(0, 4'h2, 8'h00);
    bus(1, 4'h1, r);
    bus(0, 4'h1, r);
    bus(1, 4'h0, 8'hbf);
    bus(0, 4'h0, 8'hbf);
    bus(0, 4'hf, 8'h00);
    for (int n = 0; n < 14; n++)
      chk("vector", nodeVector[n], 16'h3 + 16'(8 * n));
    chk("nm vector", nmVector, 16'h0073);
    $display("registers done");
    bus(1, 4'h0, 8'ha0);
    bus(1, 4'h1, 8'hf9);
    for (int i = 6; i < 16; i++)
      hit(16'h1 << i, 4'h0, 7'h0, i < 9 ? 15'h20 : i == 9 ? 15'h40 :
          i > 11 ? 15'h200 : 15'h0, 15'h0);
    for (int j = 0; j < 4; j++)
      hit(16'h0, 4'h1 << j, 7'h0, 15'h400 << j, 15'h0);
    bus(0, 4'h4, 8'hff);
    bus(1, 4'h4, 8'hff);
    $display("independent flags done");
    bus(1, 4'h0, 8'h20);
    hit(16'h40, 4'h0, 7'h0, 15'h0, 15'h0);
    bus(0, 4'h7, 8'h10);
    bus(1, 4'h0, 8'ha0);
    @(negedge clk) chk("held", 16'(nodeReq), 16'h20);
    bus(1, 4'h0, 8'h80);
    bus(1, 4'h0, 8'ha0);
    @(negedge clk) chk("dropped", 16'(nodeReq), 16'h0);
    bus(1, 4'h0, 8'h00);
    bus(1, 4'h2, 8'h01);
    hit(16'h0, 4'h0, 7'h01, 15'h4000, 15'h0);
    hit(16'h0, 4'h0, 7'h02, 15'h0, 15'h0);
    bus(0, 4'h5, 8'h03);
    $display("mask and nonmaskable done");
    bus(1, 4'h3, 8'hff);
    bus(1, 4'h0, 8'h92);
    hit(16'h2, 4'h0, 7'h0, 15'h2, 15'h0);
    hit(16'h10, 4'h0, 7'h0, 15'h10, 15'h10);
    bus(0, 4'h3, 8'h10);
    $display("flag as request done");
    repeat (3) @(posedge clk);
    conclude();
  end
endmodule // inve_node_enable_bench
